// ### hdl/stsi_defines.svh
// Offsets, field positions, reset values and select codes of the indicator port.
// Assumes inclusion by bare name from the design files.
`ifndef STSI_DEFINES_SVH
`define STSI_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define STSI_OFF_CTRL        8'h00
`define STSI_OFF_STATUS      8'h04
`define STSI_OFF_WRCOUNT     8'h08
`define STSI_ADDR_W          8

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define STSI_CTRL_PORT_EN    0
`define STSI_CTRL_CLEAR      1
`define STSI_CTRL_ORDER_CLR  2
`define STSI_CTRL_RESET      1'h1

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define STSI_ST_LATCH_LSB    0
`define STSI_ST_ALL_PASSED   8
`define STSI_ST_ORDER_ERR    9

// ----------------------------------------------------------------------------
// Latch output codes on address lines 4..2, one per display segment
// ----------------------------------------------------------------------------
`define STSI_SEL_SEG_A       3'h7
`define STSI_SEL_SEG_B       3'h6
`define STSI_SEL_SEG_C       3'h5
`define STSI_SEL_SEG_D       3'h4
`define STSI_SEL_SEG_E       3'h3
`define STSI_SEL_SEG_F       3'h2
`define STSI_SEL_SEG_G       3'h1
`define STSI_LATCH_RESET     8'h00

`endif

// ### hdl/stsi_pkg.sv
// Types shared by the indicator port design.
// Assumes nothing of its surroundings.
package stsi_pkg;

  // --------------------------------------------------------------------------
  // Bus response codes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    STSI_RESP_OKAY   = 2'h0,
    STSI_RESP_SLVERR = 2'h2
  } stsi_resp_t;

endpackage

// ### hdl/stsi_addr_latch.sv
// Eight-output addressable latch: one selected output takes the data bit.
// Assumes a synchronous active-low reset and a synchronous clear.
`timescale 1ns/1ps
`include "stsi_defines.svh"

module stsi_addr_latch #(
  parameter int N_OUT = 8,
  parameter int SEL_W = 3
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clear,
  input  wire logic             enable,
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic             d,
  output logic      [N_OUT-1:0] q
);

  if (N_OUT != (1 << SEL_W)) begin : g_bad_width
    $error("Output count must equal two to the select width.");
  end

  // --------------------------------------------------------------------------
  // One flip-flop per output
  // --------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N_OUT; i = i + 1) begin : g_bit
      wire hit;
      assign hit = enable && (sel == SEL_W'(i)); // [R3]
      always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
          q[i] <= 1'b0; // [R1]
        end else if (hit) begin
          q[i] <= d; // [R13]
        end
      end
    end
  endgenerate

endmodule // stsi_addr_latch

// ### hdl/stsi_indicator_port.sv
// Self-test segment indicator port with an AXI4-Lite register slave.
// Assumes processor I/O strobes synchronous to aclk and one clock domain.
//
// How it works
// [R1] Power-up clears latch; all segments lit.
// [R2] Enable on I/O write with A1 high.
// [R3] Address lines 2-4 pick the latch output.
// [R4] Seven addresses map to segments A-G.
// [R5] Segments go dark one by one per pass.
// [R6] Processor turns segment A off first.
// [R7] Segment B off after program memory checksum.
// [R8] Segment C off after working memory test.
// [R9] Segment D off after shared memory access.
// [R10] Segment E off after firmware versions match.
// [R11] Segment F off after arithmetic unit test.
// [R12] Segment G off after interrupt check.
// [R13] Data bit 0: one dark, zero lit.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "stsi_defines.svh"

module stsi_indicator_port #(
  parameter int CNT_W = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Processor I/O side.
  input  wire logic        io_request_n,
  input  wire logic        write_strobe_n,
  input  wire logic [4:1]  io_addr,
  input  wire logic        io_data0,
  output logic             arithmetic_unit_sel_n,
  output logic [6:0]       segment_drive,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt_w
    $error("Write counter width must lie between 1 and 32.");
  end

  // --------------------------------------------------------------------------
  // Decoding functions
  // --------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `STSI_OFF_CTRL) || (a == `STSI_OFF_STATUS) ||
                (a == `STSI_OFF_WRCOUNT);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic             port_en;
  logic             clear_pulse;
  logic             order_err;
  logic [CNT_W-1:0] wr_count;
  logic [7:0]       latch_q;
  logic             aw_held;
  logic [7:0]       aw_addr;
  logic             w_held;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;

  // --------------------------------------------------------------------------
  // Indicator write decode
  // --------------------------------------------------------------------------
  wire io_write    = !io_request_n && !write_strobe_n;
  wire ind_enable  = io_write && io_addr[1] && port_en; // [R2]
  wire [2:0] ind_sel = io_addr[4:2]; // [R3]
  wire seg_a_dark  = latch_q[`STSI_SEL_SEG_A];
  wire early_off   = ind_enable && io_data0 && !seg_a_dark &&
                     (ind_sel != `STSI_SEL_SEG_A);
  wire all_passed  = &latch_q[7:1];

  stsi_addr_latch #(
    .N_OUT (8),
    .SEL_W (3)
  ) u_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (clear_pulse),
    .enable  (ind_enable),
    .sel     (ind_sel),
    .d       (io_data0),
    .q       (latch_q)
  );

  // --------------------------------------------------------------------------
  // Pin outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arithmetic_unit_sel_n <= 1'b1;
    end else begin
      arithmetic_unit_sel_n <= !(io_write && !io_addr[1]); // [R2]
    end
  end

  // Segment drive is high for a lit segment, in order A..G from bit 6 down.
  wire [6:0] next_segment_drive = {
    !latch_q[`STSI_SEL_SEG_A], !latch_q[`STSI_SEL_SEG_B],
    !latch_q[`STSI_SEL_SEG_C], !latch_q[`STSI_SEL_SEG_D],
    !latch_q[`STSI_SEL_SEG_E], !latch_q[`STSI_SEL_SEG_F],
    !latch_q[`STSI_SEL_SEG_G]}; // [R4]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      segment_drive <= 7'h7F; // [R1]
    end else begin
      segment_drive <= next_segment_drive; // [R5]
    end
  end

  // --------------------------------------------------------------------------
  // Write channel
  // --------------------------------------------------------------------------
  wire aw_take      = s_axi_awvalid && s_axi_awready;
  wire w_take       = s_axi_wvalid && s_axi_wready;
  wire do_write     = aw_held && w_held && !s_axi_bvalid;
  wire next_aw_held = (aw_held || aw_take) && !do_write;
  wire next_w_held  = (w_held || w_take) && !do_write;
  wire wr_ctrl      = do_write && (aw_addr == `STSI_OFF_CTRL) && w_strb[0];
  wire wr_hit       = is_mapped(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else begin
      aw_held <= next_aw_held;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      w_held <= next_w_held;
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !next_aw_held;
      s_axi_wready  <= !next_w_held;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= stsi_pkg::STSI_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? stsi_pkg::STSI_RESP_OKAY : stsi_pkg::STSI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Control register and clear command
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_en     <= `STSI_CTRL_RESET;
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= wr_ctrl && w_data[`STSI_CTRL_CLEAR]; // [R1]
      if (wr_ctrl) begin
        port_en <= w_data[`STSI_CTRL_PORT_EN];
      end
    end
  end

  // Sticky flag: a segment switched off while segment A is still lit.
  wire order_clr = wr_ctrl && w_data[`STSI_CTRL_ORDER_CLR];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      order_err <= 1'b0;
    end else if (early_off) begin
      order_err <= 1'b1; // [R6]
    end else if (order_clr) begin
      order_err <= 1'b0;
    end
  end

  // Counts once per strobe rather than once per cycle of a long strobe.
  logic write_strobe_n_q;

  // Count of enabled indicator write cycles.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_count <= '0;
    end else if (ind_enable && write_strobe_n_q) begin
      wr_count <= wr_count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_strobe_n_q <= 1'b1;
    end else begin
      write_strobe_n_q <= !ind_enable;
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  wire ar_take     = s_axi_arvalid && s_axi_arready;
  wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

  wire [31:0] rd_ctrl   = {31'h0000_0000, port_en};
  wire [31:0] rd_status = {22'h00_0000, order_err, all_passed, latch_q};
  wire [31:0] rd_count  = 32'(wr_count);
  wire [31:0] rd_value  = (s_axi_araddr == `STSI_OFF_CTRL)   ? rd_ctrl   :
                          (s_axi_araddr == `STSI_OFF_STATUS) ? rd_status :
                          (s_axi_araddr == `STSI_OFF_WRCOUNT) ? rd_count :
                          32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= stsi_pkg::STSI_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= rd_value;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? stsi_pkg::STSI_RESP_OKAY
                                             : stsi_pkg::STSI_RESP_SLVERR;
    end
  end

endmodule // stsi_indicator_port

// ### sim/stsi_cpu_model.sv
// Board processor model issuing indicator I/O write cycles.
// Assumes the clock of the port and one request at a time.
`timescale 1ns/1ps
module stsi_cpu_model (
  input  wire logic       aclk,
  output logic            io_request_n,
  output logic            write_strobe_n,
  output logic      [4:1] io_addr,
  output logic            io_data0
);
  // ------
  // Cycles
  // ------
  initial begin
    io_request_n = 1'b1;
    write_strobe_n = 1'b1;
    io_addr = 4'h0;
    io_data0 = 1'b0;
  end
  task automatic io_wr(input logic [4:1] a, input logic rq_n, input logic wr_n, input logic d);
    @(posedge aclk);
    io_request_n <= rq_n;
    write_strobe_n <= wr_n;
    io_addr <= a;
    io_data0 <= d;
    @(posedge aclk);
    io_request_n <= 1'b1;
    write_strobe_n <= 1'b1;
    io_addr <= ~a;
    io_data0 <= ~d;
  endtask
  function automatic logic [4:1] pass_addr(input int i);
    case (i)
      0: pass_addr = 4'hF;
      1: pass_addr = 4'hD;
      2: pass_addr = 4'hB;
      3: pass_addr = 4'h9;
      4: pass_addr = 4'h7;
      5: pass_addr = 4'h5;
      default: pass_addr = 4'h3;
    endcase
  endfunction
endmodule // stsi_cpu_model

// ### sim/stsi_indicator_port_chk.sv
// Assertions on the indicator pins and register bus of the port.
// Assumes a bind to stsi_indicator_port and one clock domain.
`timescale 1ns/1ps
module stsi_indicator_port_chk #(
  parameter int CNT_W = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        io_request_n,
  input wire logic        write_strobe_n,
  input wire logic [4:1]  io_addr,
  input wire logic        io_data0,
  input wire logic        arithmetic_unit_sel_n,
  input wire logic [6:0]  segment_drive,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  // ------
  // Checks
  // ------
  logic       en;
  logic [3:0] quiet;
  logic [7:0] aw_q;
  logic       bv_q;
  logic       ws_q;
  logic       wd_q;
  wire logic  wr_io = !io_request_n && !write_strobe_n;
  wire logic  wr_en = wr_io && io_addr[1] && en;
  wire logic  aw_t = s_axi_awvalid && s_axi_awready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en <= 1'b1;
      quiet <= 4'h0;
      aw_q <= 8'h00;
      bv_q <= 1'b0;
      ws_q <= 1'b0;
      wd_q <= 1'b0;
    end else begin
      if (aw_t) aw_q <= s_axi_awaddr;
      bv_q <= s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        ws_q <= s_axi_wstrb[0];
        wd_q <= s_axi_wdata[0];
      end
      if (s_axi_bvalid && !bv_q && aw_q == 8'h00 && ws_q)
        en <= wd_q;
      quiet <= s_axi_awvalid ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset; $rose(aresetn) |-> segment_drive == 7'h7F; endproperty
  a_reset: assert property (p_reset) else $error("segments not lit after reset");
  property p_seg_set;
    wr_en && io_addr[4:2] != 3'h0 |->
      ##2 segment_drive[$past(io_addr[4:2], 2) - 3'h1] == !$past(io_data0, 2);
  endproperty
  a_seg_set: assert property (p_seg_set) else $error("segment not updated");
  property p_seg_hold; !wr_en && quiet == 4'hF |-> ##2 $stable(segment_drive); endproperty
  a_seg_hold: assert property (p_seg_hold) else $error("segment changed unasked");
  property p_au_low; wr_io && !io_addr[1] |=> !arithmetic_unit_sel_n; endproperty
  a_au_low: assert property (p_au_low) else $error("unit select not low");
  property p_au_high; !(wr_io && !io_addr[1]) |=> arithmetic_unit_sel_n; endproperty
  a_au_high: assert property (p_au_high) else $error("unit select low");
  property p_bresp; s_axi_bvalid && aw_q > 8'h08 |-> s_axi_bresp == 2'h2; endproperty
  a_bresp: assert property (p_bresp) else $error("unmapped write not refused");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  c_off: cover property (wr_en && io_data0);
  c_au: cover property (!arithmetic_unit_sel_n);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // stsi_indicator_port_chk
bind stsi_indicator_port stsi_indicator_port_chk #(.CNT_W(CNT_W)) u_chk (.aclk, .aresetn,
  .io_request_n, .write_strobe_n, .io_addr, .io_data0, .arithmetic_unit_sel_n,
  .segment_drive, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid);

// ### sim/stsi_indicator_port_tb.sv
// Self-checking bench for the segment indicator port.
// Assumes the processor model drives the pins and the checker is bound.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module stsi_indicator_port_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, en = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        io_request_n, write_strobe_n, io_data0, arithmetic_unit_sel_n;
  logic [4:1]  io_addr;
  logic [6:0]  segment_drive;
  logic [7:1]  lat = 7'h00;
  logic        oe = 1'b0;
  int          mismatches = 0, n_compared = 0, cycles = 0, cnt = 0, r;
  integer      seed = 13;
  // ------
  // Tests
  // ------
  always #2 aclk = ~aclk;
  stsi_cpu_model u_cpu (.aclk, .io_request_n, .write_strobe_n, .io_addr, .io_data0);
  stsi_indicator_port u_dut (.aclk, .aresetn, .io_request_n, .write_strobe_n, .io_addr,
    .io_data0, .arithmetic_unit_sel_n, .segment_drive, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
      rs = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic iow(input logic [4:1] a, input logic rq_n, input logic wr_n, input logic d);
    u_cpu.io_wr(a, rq_n, wr_n, d);
    if (!rq_n && !wr_n && a[1] && en) begin
      cnt++;
      if (d && a[4:2] != 3'h7 && !lat[7]) oe = 1'b1;
      if (a[4:2] != 3'h0) lat[a[4:2]] = d;
    end
    #1;
    `CHK(arithmetic_unit_sel_n, !(!rq_n && !wr_n && !a[1]))
    @(posedge aclk);
    #1;
    `CHK(segment_drive, ~lat)
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK(segment_drive, 7'h7F)
    axi_rd(8'h04, rd, resp);
    `CHK(rd[9:0], 10'h000)
    for (int i = 0; i < 7; i++) begin
      iow(u_cpu.pass_addr(i), 1'b0, 1'b0, 1'b1);
      `CHK(segment_drive, 7'h7F >> (i + 1))
    end
    axi_rd(8'h04, rd, resp);
    `CHK(rd[9:0], 10'h1FE)
    axi_rd(8'h08, rd, resp);
    `CHK(rd[15:0], cnt[15:0])
    axi_wr(8'h00, 32'h3, resp);
    lat = 7'h00;
    repeat (4) @(posedge aclk);
    #1;
    `CHK(segment_drive, 7'h7F)
    for (int k = 0; k < 60; k++) begin
      if (k == 40) begin
        axi_wr(8'h00, 32'h0, resp);
        en = 1'b0;
      end
      r = $random(seed);
      iow(r[3:0], r[4] & r[5], r[6] & r[7], r[8]);
    end
    axi_wr(8'h00, 32'h1, resp);
    axi_rd(8'h04, rd, resp);
    `CHK({rd[9], rd[7:1]}, {oe, lat})
    axi_rd(8'h08, rd, resp);
    `CHK(rd[15:0], cnt[15:0])
    axi_wr(8'h00, 32'h5, resp);
    oe = 1'b0;
    axi_rd(8'h04, rd, resp);
    `CHK(rd[9], oe)
    axi_wr(8'h10, 32'h3, resp);
    `CHK(resp, 2'h2)
    axi_rd(8'h3C, rd, resp);
    `CHK({resp, rd}, {2'h2, 32'h0})
    stop_test;
  end
endmodule // stsi_indicator_port_tb
